// ### spm_pin_mux.sv
// shared port pin mux: apb registers, pin routing, pull and slew control
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module spm_pin_mux
    import spm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        core_power_down,
    input  wire logic [3:0]  audio2_out,
    input  wire logic [3:0]  audio2_oe,
    output logic      [3:0]  audio2_in,
    input  wire logic [3:0]  audio3_out,
    input  wire logic [3:0]  audio3_oe,
    output logic      [3:0]  audio3_in,
    input  wire logic [3:0]  uart_out,
    input  wire logic [3:0]  uart_oe,
    output logic      [3:0]  uart_in,
    input  wire logic [6:0]  spi_out,
    input  wire logic [6:0]  spi_oe,
    output logic      [6:0]  spi_in,
    input  wire logic [7:0]  gpio_shared_out,
    input  wire logic [7:0]  gpio_shared_oe,
    output logic      [7:0]  gpio_shared_in,
    input  wire logic [5:0]  gpio_line_out,
    input  wire logic [5:0]  gpio_line_oe,
    output logic      [5:0]  gpio_line_in,
    input  wire logic [7:0]  shared_pad_in,
    output logic      [7:0]  shared_pad_out,
    output logic      [7:0]  shared_pad_oe,
    input  wire logic [6:0]  spi_pad_in,
    output logic      [6:0]  spi_pad_out,
    output logic      [6:0]  spi_pad_oe,
    input  wire logic [5:0]  gpio_pad_in,
    output logic      [5:0]  gpio_pad_out,
    output logic      [5:0]  gpio_pad_oe,
    output logic      [15:0] pull_en_first,
    output logic      [15:0] pull_en_second,
    output logic      [15:0] pull_en_third,
    output logic             busholder_en,
    output logic             slow_slew_clock_output_pin,
    output logic             slow_slew_external_memory_interface
);

    // =========================================================
    // declarations
    localparam int unsigned SYNC_W = 22;

    logic [2:0]        route_mode_q;
    logic [15:0]       slew_q;
    logic [15:0]       inhibit1_q;
    logic [15:0]       inhibit2_q;
    logic [15:0]       inhibit3_q;
    logic [31:0]       prdata_q;
    logic [31:0]       rdata_d;
    logic              pready_q;
    logic              pslverr_q;
    logic              hit_d;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] raw_in;
    logic [7:0]        shared_in_s;
    logic [6:0]        spi_pad_in_s;
    logic [5:0]        gpio_pad_in_s;
    logic              power_down_s;
    logic              write_en;
    logic              setup_phase;
    logic [13:0]       reg_idx;
    logic [15:0]       wr_mask;
    spm_func_type      group_a_func;
    spm_func_type      group_b_func;
    logic              dedicated_en;
    logic [7:0]        shared_out_d;
    logic [7:0]        shared_oe_d;
    logic [15:0]       status_d;

    // =========================================================
    // apb access decode
    assign setup_phase = psel && !penable;
    assign write_en    = psel && penable && pready_q && pwrite && hit_d;
    assign reg_idx     = paddr[15:2];
    assign wr_mask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb
    begin
        hit_d   = 1'b1;
        rdata_d = 32'h0000_0000;
        if (reg_idx == SPM_IDX_BUS_SEL)
            rdata_d[SPM_MODE_LSB +: SPM_MODE_W] = route_mode_q;
        else if (reg_idx == SPM_IDX_SLEW)
            rdata_d[15:0] = slew_q;
        else if (reg_idx == SPM_IDX_INHIBIT_1)
            rdata_d[15:0] = inhibit1_q;
        else if (reg_idx == SPM_IDX_INHIBIT_2)
            rdata_d[15:0] = inhibit2_q;
        else if (reg_idx == SPM_IDX_INHIBIT_3)
            rdata_d[15:0] = inhibit3_q;
        else if (reg_idx == SPM_IDX_STATUS)
            rdata_d[15:0] = status_d;
        else
            hit_d = 1'b0;
    end

    // one wait-free access phase: ready rises in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= setup_phase;
            pslverr_q <= setup_phase && !hit_d;
            prdata_q  <= (setup_phase && !pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // =========================================================
    // registers written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            route_mode_q <= SPM_MODE_RESET;
        end
        else if (write_en && reg_idx == SPM_IDX_BUS_SEL && pstrb[1])
        begin
            // only place that steers the routing
            route_mode_q <= pwdata[SPM_MODE_LSB +: SPM_MODE_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slew_q <= SPM_SLEW_RESET;
        end
        else if (write_en && reg_idx == SPM_IDX_SLEW)
            slew_q <= (slew_q & ~wr_mask) | (pwdata[15:0] & wr_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {inhibit1_q, inhibit2_q, inhibit3_q} <= {3{SPM_INHIBIT_RESET}};
        end
        else if (write_en)
        begin
            if (reg_idx == SPM_IDX_INHIBIT_1)
                inhibit1_q <= (inhibit1_q & ~wr_mask) | (pwdata[15:0] & wr_mask);
            if (reg_idx == SPM_IDX_INHIBIT_2)
                inhibit2_q <= (inhibit2_q & ~wr_mask) | (pwdata[15:0] & wr_mask);
            if (reg_idx == SPM_IDX_INHIBIT_3)
                inhibit3_q <= (inhibit3_q & ~wr_mask) | (pwdata[15:0] & wr_mask);
        end
    end

    // =========================================================
    // pad input synchronisers
    assign raw_in = {core_power_down, gpio_pad_in, spi_pad_in, shared_pad_in};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {sync1_q, sync2_q} <= '0;
        end
        else
        begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    assign shared_in_s   = sync2_q[7:0];
    assign spi_pad_in_s  = sync2_q[14:8];
    assign gpio_pad_in_s = sync2_q[20:15];
    assign power_down_s  = sync2_q[21];

    // =========================================================
    // route decode
    spm_route_decode u_decode (
        .route_mode   (route_mode_q),
        .group_a_func (group_a_func),
        .group_b_func (group_b_func),
        .dedicated_en (dedicated_en)
    );

    assign status_d = {6'h00, power_down_s, dedicated_en,
                       1'b0, 3'(group_b_func), 1'b0, 3'(group_a_func)};

    // =========================================================
    // shared pins, first group 0..3 and second group 4..7
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_shared
            always_comb
            begin
                shared_out_d[i] = 1'b0;
                shared_oe_d[i]  = 1'b0;
                case (group_a_func)
                    SPM_FN_AUDIO:
                    begin
                        shared_out_d[i] = audio2_out[i];
                        shared_oe_d[i]  = audio2_oe[i];
                    end
                    SPM_FN_GPIO:
                    begin
                        shared_out_d[i] = gpio_shared_out[i];
                        shared_oe_d[i]  = gpio_shared_oe[i];
                    end
                    SPM_FN_SPI:
                    begin
                        shared_out_d[i] = spi_out[i];
                        shared_oe_d[i]  = spi_oe[i];
                    end
                    default: shared_out_d[i] = 1'b0;
                endcase
                shared_out_d[i+4] = 1'b0;
                shared_oe_d[i+4]  = 1'b0;
                case (group_b_func)
                    SPM_FN_UART:
                    begin
                        shared_out_d[i+4] = uart_out[i];
                        shared_oe_d[i+4]  = uart_oe[i];
                    end
                    SPM_FN_GPIO:
                    begin
                        shared_out_d[i+4] = gpio_shared_out[i+4];
                        shared_oe_d[i+4]  = gpio_shared_oe[i+4];
                    end
                    SPM_FN_AUDIO:
                    begin
                        shared_out_d[i+4] = audio3_out[i];
                        shared_oe_d[i+4]  = audio3_oe[i];
                    end
                    default: shared_out_d[i+4] = 1'b0;
                endcase
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    {audio2_in[i], audio3_in[i], uart_in[i], spi_in[i]} <= 4'h0;
                end
                else
                begin
                    audio2_in[i] <= (group_a_func == SPM_FN_AUDIO) && shared_in_s[i];
                    uart_in[i]   <= (group_b_func == SPM_FN_UART) && shared_in_s[i+4];
                    audio3_in[i] <= (group_b_func == SPM_FN_AUDIO) && shared_in_s[i+4];
                    // first four spi lines come from either pin set
                    spi_in[i]    <= ((group_a_func == SPM_FN_SPI) && shared_in_s[i])
                                 || (dedicated_en && spi_pad_in_s[i]);
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {shared_pad_out, shared_pad_oe, gpio_shared_in} <= 24'h000000;
        end
        else
        begin
            shared_pad_out <= shared_out_d;
            shared_pad_oe  <= shared_oe_d;
            gpio_shared_in[3:0] <= (group_a_func == SPM_FN_GPIO) ? shared_in_s[3:0] : 4'h0;
            gpio_shared_in[7:4] <= (group_b_func == SPM_FN_GPIO) ? shared_in_s[7:4] : 4'h0;
        end
    end

    // =========================================================
    // dedicated spi and gpio pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {spi_pad_out, spi_pad_oe, spi_in[6:4]} <= 17'h00000;
            {gpio_pad_out, gpio_pad_oe, gpio_line_in} <= 18'h00000;
        end
        else
        begin
            spi_pad_out  <= dedicated_en ? spi_out : 7'h00;
            spi_pad_oe   <= dedicated_en ? spi_oe : 7'h00;
            spi_in[6:4]  <= dedicated_en ? spi_pad_in_s[6:4] : 3'h0;
            gpio_pad_out <= dedicated_en ? gpio_line_out : 6'h00;
            gpio_pad_oe  <= dedicated_en ? gpio_line_oe : 6'h00;
            gpio_line_in <= dedicated_en ? gpio_pad_in_s : 6'h00;
        end
    end

    // =========================================================
    // pull resistors, busholder and slew
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {pull_en_first, pull_en_second, pull_en_third} <= 48'h0;
            busholder_en   <= 1'b0;
        end
        else
        begin
            pull_en_first  <= power_down_s ? 16'h0000 : ~inhibit1_q;
            pull_en_second <= power_down_s ? 16'h0000 : ~inhibit2_q;
            pull_en_third  <= power_down_s ? 16'h0000 : ~inhibit3_q;
            busholder_en   <= power_down_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {slow_slew_clock_output_pin, slow_slew_external_memory_interface} <= 2'b00;
        end
        else
        begin
            // edge rate only; drive strength is untouched
            slow_slew_clock_output_pin          <= slew_q[SPM_SLEW_CLOCK_OUTPUT_PIN_BIT];
            slow_slew_external_memory_interface <= slew_q[SPM_SLEW_EXTERNAL_MEMORY_INTERFACE_BIT];
        end
    end

endmodule

`default_nettype wire

// ### spm_pkg.sv
// shared port pin mux constants, register map and types
package spm_pkg;

    // =========================================================
    // bus geometry
    localparam int unsigned SPM_ADDR_W  = 16;
    localparam int unsigned SPM_DATA_W  = 32;
    localparam int unsigned SPM_REG_W   = 16;
    localparam int unsigned SPM_IDX_W   = 14;

    // =========================================================
    // register indices, byte address is four times the index
    localparam logic [13:0] SPM_IDX_BUS_SEL   = 14'h1c10;
    localparam logic [13:0] SPM_IDX_SLEW      = 14'h1c16;
    localparam logic [13:0] SPM_IDX_INHIBIT_1 = 14'h1c17;
    localparam logic [13:0] SPM_IDX_INHIBIT_2 = 14'h1c18;
    localparam logic [13:0] SPM_IDX_INHIBIT_3 = 14'h1c19;
    localparam logic [13:0] SPM_IDX_STATUS    = 14'h1c1a;

    // =========================================================
    // field positions
    localparam int unsigned SPM_MODE_LSB        = 12;
    localparam int unsigned SPM_MODE_W          = 3;
    localparam int unsigned SPM_SLEW_CLOCK_OUTPUT_PIN_BIT = 0;
    localparam int unsigned SPM_SLEW_EXTERNAL_MEMORY_INTERFACE_BIT   = 1;
    localparam int unsigned SPM_ST_GRP_A_LSB    = 0;
    localparam int unsigned SPM_ST_GRP_B_LSB    = 4;
    localparam int unsigned SPM_ST_DEDICATED    = 8;
    localparam int unsigned SPM_ST_POWER_DOWN   = 9;

    // =========================================================
    // reset values
    localparam logic [2:0]  SPM_MODE_RESET    = 3'h0;
    localparam logic [15:0] SPM_SLEW_RESET    = 16'h0000;
    localparam logic [15:0] SPM_INHIBIT_RESET = 16'h0000;

    // =========================================================
    // shared-port route codes
    localparam logic [2:0] SPM_MODE_1    = 3'h1;
    localparam logic [2:0] SPM_MODE_2    = 3'h2;
    localparam logic [2:0] SPM_MODE_3    = 3'h3;
    localparam logic [2:0] SPM_MODE_4    = 3'h4;
    localparam logic [2:0] SPM_MODE_5    = 3'h5;
    localparam logic [2:0] SPM_MODE_6    = 3'h6;

    typedef enum logic [2:0] {
        SPM_FN_NONE,
        SPM_FN_AUDIO,
        SPM_FN_GPIO,
        SPM_FN_SPI,
        SPM_FN_UART
    } spm_func_type;

endpackage

// ### spm_route_decode.sv
// decode of the shared-port route field into pin group functions
`timescale 1ns/1ps
`default_nettype none

module spm_route_decode
    import spm_pkg::*;
(
    input  wire logic [2:0] route_mode,
    output var spm_func_type group_a_func,
    output var spm_func_type group_b_func,
    output logic            dedicated_en
);

    always_comb
    begin
        group_a_func = SPM_FN_NONE;
        group_b_func = SPM_FN_NONE;
        dedicated_en = 1'b0;
        case (route_mode)
            SPM_MODE_1:
            begin
                group_a_func = SPM_FN_AUDIO;
                group_b_func = SPM_FN_UART;
                dedicated_en = 1'b1;
            end
            SPM_MODE_2:
            begin
                group_a_func = SPM_FN_GPIO;
                group_b_func = SPM_FN_GPIO;
            end
            SPM_MODE_3:
            begin
                group_a_func = SPM_FN_SPI;
                group_b_func = SPM_FN_AUDIO;
            end
            SPM_MODE_4:
            begin
                group_a_func = SPM_FN_AUDIO;
                group_b_func = SPM_FN_UART;
            end
            SPM_MODE_5:
            begin
                group_a_func = SPM_FN_SPI;
                group_b_func = SPM_FN_UART;
            end
            SPM_MODE_6:
            begin
                group_a_func = SPM_FN_AUDIO;
                group_b_func = SPM_FN_AUDIO;
                dedicated_en = 1'b1;
            end
            default:
            begin
                dedicated_en = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ### spm_pin_mux_checker.sv
// checker of apb timing, pull, busholder and slew outputs
`timescale 1ns/1ps
`default_nettype none

module spm_pin_mux_checker
    import spm_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        core_power_down,
    input wire logic [7:0]  shared_pad_oe,
    input wire logic [15:0] pull_en_first,
    input wire logic [15:0] pull_en_third,
    input wire logic        busholder_en,
    input wire logic        slow_slew_clock_output_pin
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // =========================================================
    // completed write
    logic wr;
    assign wr = psel && penable && pready && pwrite;

    // =========================================================
    // bus timing
    property p_ans;
        psel && !penable |=> pready;
    endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rd0;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("read data outside answer");

    // =========================================================
    // pins, pulls and slew
    property p_rst;
        $rose(presetn) |-> shared_pad_oe == 8'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("shared pin driven at reset");
    property p_hold;
        $rose(core_power_down) |-> ##[2:3] busholder_en;
    endproperty
    a_hold: assert property (p_hold) else $error("busholder late");
    property p_nopull;
        busholder_en |-> pull_en_first == 16'h0 && pull_en_third == 16'h0;
    endproperty
    a_nopull: assert property (p_nopull) else $error("pull on in power down");
    property p_inh;
        wr && paddr == {SPM_IDX_INHIBIT_3, 2'b00} && pstrb == 4'hf
            |-> ##2 busholder_en || pull_en_third == ~$past(pwdata[15:0], 2);
    endproperty
    a_inh: assert property (p_inh) else $error("third pull wrong");
    property p_mask;
        wr && paddr == {SPM_IDX_INHIBIT_1, 2'b00} && pstrb == 4'h1
            |-> ##2 busholder_en || pull_en_first[15:8] == $past(pull_en_first[15:8], 2);
    endproperty
    a_mask: assert property (p_mask) else $error("masked lane changed");
    property p_slew;
        wr && paddr == {SPM_IDX_SLEW, 2'b00} && pstrb[0]
            |-> ##2 slow_slew_clock_output_pin == $past(pwdata[0], 2);
    endproperty
    a_slew: assert property (p_slew) else $error("slew select wrong");
endmodule

`default_nettype wire

// ### spm_board_model.sv
// board model: external drivers on pins the device leaves undriven
`timescale 1ns/1ps
`default_nettype none

module spm_board_model
(
    input  wire logic [7:0] shared_pad_out,
    input  wire logic [7:0] shared_pad_oe,
    input  wire logic [7:0] shared_ext,
    output logic      [7:0] shared_pad_in,
    input  wire logic [6:0] spi_pad_out,
    input  wire logic [6:0] spi_pad_oe,
    input  wire logic [6:0] spi_ext,
    output logic      [6:0] spi_pad_in,
    input  wire logic [5:0] gpio_pad_out,
    input  wire logic [5:0] gpio_pad_oe,
    input  wire logic [5:0] gpio_ext,
    output logic      [5:0] gpio_pad_in
);
    // external driver wins wherever the device does not drive
    assign shared_pad_in = (shared_pad_oe & shared_pad_out) | (~shared_pad_oe & shared_ext);
    assign spi_pad_in    = (spi_pad_oe & spi_pad_out) | (~spi_pad_oe & spi_ext);
    assign gpio_pad_in   = (gpio_pad_oe & gpio_pad_out) | (~gpio_pad_oe & gpio_ext);
endmodule

`default_nettype wire

// ### test_spm_pin_mux.sv
// self-checking bench of the shared port pin mux
`timescale 1ns/1ps
`default_nettype none

module test_spm_pin_mux
    import spm_pkg::*;
;
    localparam logic [7:0] SX = 8'hc6;
    localparam logic [6:0] PX = 7'h35;
    localparam logic [5:0] GX = 6'h1b;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, core_power_down;
    logic [15:0] paddr, pull_en_first, pull_en_second, pull_en_third;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, audio2_out, audio2_oe, audio2_in, audio3_out, audio3_oe, audio3_in;
    logic [3:0]  uart_out, uart_oe, uart_in, ea, eb, oa, ob;
    logic [6:0]  spi_out, spi_oe, spi_in, spi_pad_in, spi_pad_out, spi_pad_oe;
    logic [7:0]  gpio_shared_out, gpio_shared_oe, gpio_shared_in;
    logic [7:0]  shared_pad_in, shared_pad_out, shared_pad_oe;
    logic [5:0]  gpio_line_out, gpio_line_oe, gpio_line_in, gpio_pad_in, gpio_pad_out, gpio_pad_oe;
    logic        busholder_en, slow_slew_clock_output_pin, slow_slew_external_memory_interface;
    logic [15:0] st;
    logic        ded;
    int          errors, samples_checked;

    spm_pin_mux spm_pin_mux_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .core_power_down, .audio2_out,
        .audio2_oe, .audio2_in, .audio3_out, .audio3_oe, .audio3_in, .uart_out, .uart_oe,
        .uart_in, .spi_out, .spi_oe, .spi_in, .gpio_shared_out, .gpio_shared_oe,
        .gpio_shared_in, .gpio_line_out, .gpio_line_oe, .gpio_line_in, .shared_pad_in,
        .shared_pad_out, .shared_pad_oe, .spi_pad_in, .spi_pad_out, .spi_pad_oe,
        .gpio_pad_in, .gpio_pad_out, .gpio_pad_oe, .pull_en_first, .pull_en_second,
        .pull_en_third, .busholder_en, .slow_slew_clock_output_pin,
        .slow_slew_external_memory_interface);
    spm_board_model spm_board_model_inst (.shared_pad_out, .shared_pad_oe,
        .shared_ext(SX), .shared_pad_in, .spi_pad_out, .spi_pad_oe, .spi_ext(PX),
        .spi_pad_in, .gpio_pad_out, .gpio_pad_oe, .gpio_ext(GX), .gpio_pad_in);

    always #20 pclk = ~pclk;

    // =========================================================
    // helpers
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [13:0] ix, input logic [31:0] d,
                       input logic [3:0] s, output logic [32:0] r);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {ix, 2'b00};
        pwdata <= d;
        pstrb  <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            errors++;
        r = {prdata, pslverr};
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] ix, input logic [31:0] d, input logic [3:0] s);
        logic [32:0] r;
        apb(1'b1, ix, d, s, r);
    endtask

    task automatic rdc(input logic [13:0] ix, input logic [31:0] e, input logic ee);
        logic [32:0] r;
        apb(1'b0, ix, 32'h0, 4'h0, r);
        chk("read", {31'h0, e, ee}, {31'h0, r});
    endtask

    function automatic logic [15:0] exp_st(input logic [2:0] m);
        logic [2:0] a, b;
        a = (m == 1 || m == 4 || m == 6) ? SPM_FN_AUDIO : m == 2 ? SPM_FN_GPIO :
            (m == 3 || m == 5) ? SPM_FN_SPI : SPM_FN_NONE;
        b = (m == 1 || m == 4 || m == 5) ? SPM_FN_UART : m == 2 ? SPM_FN_GPIO :
            (m == 3 || m == 6) ? SPM_FN_AUDIO : SPM_FN_NONE;
        return {7'h0, m == 1 || m == 6, 1'b0, b, 1'b0, a};
    endfunction

    task automatic drive(input logic on);
        {audio2_oe, audio3_oe, uart_oe, spi_oe, gpio_shared_oe, gpio_line_oe} <= {33{on}};
    endtask

    task automatic stop_test();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // =========================================================
    // tests
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, core_power_down} = 6'h0;
        {paddr, pwdata, pstrb} = '0;
        {audio2_out, audio3_out, uart_out} = 12'h421;
        {spi_out, gpio_shared_out, gpio_line_out} = {7'h48, 8'h5a, 6'h2d};
        {audio2_oe, audio3_oe, uart_oe, spi_oe, gpio_shared_oe, gpio_line_oe} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 4; k++)
            rdc(SPM_IDX_SLEW + 14'(k), 32'h0, 1'b0);
        rdc(SPM_IDX_BUS_SEL, 32'h0, 1'b0);
        chk("pull", 64'hffffffffffff, {pull_en_first, pull_en_second, pull_en_third});
        for (int m = 0; m < 8; m++)
        begin
            wr(SPM_IDX_BUS_SEL, 32'(m) << 12, 4'h3);
            drive(1'b1);
            st = exp_st(3'(m));
            ded = st[8];
            rdc(SPM_IDX_STATUS, {16'h0, st}, 1'b0);
            repeat (2) @(posedge pclk);
            ea = st[2:0] == SPM_FN_AUDIO ? audio2_out : st[2:0] == SPM_FN_GPIO ?
                 gpio_shared_out[3:0] : st[2:0] == SPM_FN_SPI ? spi_out[3:0] : 4'h0;
            eb = st[6:4] == SPM_FN_UART ? uart_out : st[6:4] == SPM_FN_GPIO ?
                 gpio_shared_out[7:4] : st[6:4] == SPM_FN_AUDIO ? audio3_out : 4'h0;
            oa = st[2:0] == 3'h0 ? 4'h0 : 4'hf;
            ob = st[6:4] == 3'h0 ? 4'h0 : 4'hf;
            chk("shared", {eb, ea, ob, oa}, {shared_pad_out, shared_pad_oe});
            chk("dedicated", ded ? {spi_out, 7'h7f, gpio_line_out, 6'h3f} : 64'h0,
                {spi_pad_out, spi_pad_oe, gpio_pad_out, gpio_pad_oe});
            drive(1'b0);
            repeat (5) @(posedge pclk);
            chk("inputs", {ded ? GX : 6'h0,
                ded ? PX : st[2:0] == SPM_FN_SPI ? {3'h0, SX[3:0]} : 7'h0,
                st[6:4] == SPM_FN_GPIO ? SX : 8'h0,
                st[6:4] == SPM_FN_UART ? SX[7:4] : 4'h0,
                st[6:4] == SPM_FN_AUDIO ? SX[7:4] : 4'h0,
                st[2:0] == SPM_FN_AUDIO ? SX[3:0] : 4'h0},
                {gpio_line_in, spi_in, gpio_shared_in, uart_in, audio3_in, audio2_in});
        end
        wr(SPM_IDX_BUS_SEL, 32'h2000, 4'h1);
        rdc(SPM_IDX_BUS_SEL, 32'h7000, 1'b0);
        wr(SPM_IDX_STATUS, 32'hffff, 4'hf);
        rdc(SPM_IDX_STATUS, {16'h0, exp_st(3'h7)}, 1'b0);
        rdc(14'h1c11, 32'h0, 1'b1);
        wr(SPM_IDX_INHIBIT_1, 32'h1234, 4'h3);
        wr(SPM_IDX_INHIBIT_1, 32'hffff, 4'h1);
        wr(SPM_IDX_INHIBIT_2, 32'h00f0, 4'h3);
        wr(SPM_IDX_INHIBIT_3, 32'hfffc, 4'hf);
        rdc(SPM_IDX_INHIBIT_1, 32'h12ff, 1'b0);
        chk("pull", 64'hed00ff0f0003, {pull_en_first, pull_en_second, pull_en_third});
        wr(SPM_IDX_SLEW, 32'h3, 4'h1);
        rdc(SPM_IDX_SLEW, 32'h3, 1'b0);
        chk("slew", 64'h3, {slow_slew_external_memory_interface, slow_slew_clock_output_pin});
        wr(SPM_IDX_SLEW, 32'h1, 4'h1);
        repeat (2) @(posedge pclk);
        chk("slew", 64'h1, {slow_slew_external_memory_interface, slow_slew_clock_output_pin});
        core_power_down <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("hold", 64'h1000000000000,
            {busholder_en, pull_en_first, pull_en_second, pull_en_third});
        rdc(SPM_IDX_STATUS, {16'h0, exp_st(3'h7) | 16'h0200}, 1'b0);
        core_power_down <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("hold", 64'hed00ff0f0003,
            {busholder_en, pull_en_first, pull_en_second, pull_en_third});
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(SPM_IDX_BUS_SEL, 32'h0, 1'b0);
        stop_test();
    end

    initial
    begin
        #400000;
        errors++;
        stop_test();
    end
endmodule

bind spm_pin_mux spm_pin_mux_checker spm_pin_mux_checker_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .core_power_down, .shared_pad_oe, .pull_en_first, .pull_en_third, .busholder_en,
    .slow_slew_clock_output_pin);

`default_nettype wire
